// ### tb/dwb_link_sva.sv
/*
  Checker for the write-burst link: select, command, termination, lanes.
  Assumes it sits beside the link interface, clocked by ref_clk.
*/
`timescale 1ns/1ps
module dwb_link_sva
  import dwb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ck,
  input wire logic cs_n,
  input wire logic [1:0] cmd,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic on_die_termination,
  input wire logic [DQ_W-1:0] dq,
  input wire logic lane_n
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // helper state: mode as seen on the wire, run-length counters
  logic [ADDR_W-1:0] mode_r;
  logic [3:0] beats_r;
  logic [9:0] odt_cnt_r;
  logic [9:0] cs_cnt_r;
  logic [9:0] odt_exp;
  logic [9:0] cal_exp;
  logic chop;
  assign chop = mode_r[1:0] == BL_CHOP ||
                (mode_r[1:0] == BL_OTF && !addr[SEL_BIT]);
  assign odt_exp = {7'(mode_r[MR_AL_LSB+:5]) + 7'(mode_r[MR_CWL_LSB+:5])
                    + 7'(beats_r), 3'h0};
  assign cal_exp = {4'h0, mode_r[MR_CAL_LSB+:3], 3'h0} - 10'h7;
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      mode_r <= MR_RESET;
      beats_r <= BEATS_FULL;
      odt_cnt_r <= '0;
      cs_cnt_r <= '0;
    end
    else
    begin
      if (cmd == CMD_MRS)
        mode_r <= addr;
      if (cmd == CMD_WRITE)
        beats_r <= chop ? BEATS_CHOP : BEATS_FULL;
      odt_cnt_r <= on_die_termination ? odt_cnt_r + 10'h1 : '0;
      // saturate so a long idle never wraps into a legal gap
      cs_cnt_r <= !cs_n ? 10'h1 : cs_cnt_r + 10'(cs_cnt_r != 10'h3FF);
    end
  end
  // ==========================================================
  // properties
  property p_stand;
    ($changed(cs_n) || $changed(cmd) || $changed(addr) || $changed(on_die_termination)
     || $changed(dq) || $changed(lane_n)) |-> $fell(ck);
  endproperty
  a_stand: assert property (p_stand) else $error("link changed off edge");
  property p_cs_len;
    $fell(cs_n) |=> (!cs_n) [*7] ##1 cs_n;
  endproperty
  a_cs_len: assert property (p_cs_len) else $error("select length");
  property p_cal;
    (cmd != CMD_NOP && $past(cmd) == CMD_NOP) |->
      ((mode_r[MR_CAL_LSB+:3] == 3'h0) ? !cs_n
       : (cs_n && cs_cnt_r == cal_exp));
  endproperty
  a_cal: assert property (p_cal) else $error("select lead wrong");
  property p_odt_cmd;
    $rose(on_die_termination) |-> cmd == CMD_WRITE;
  endproperty
  a_odt_cmd: assert property (p_odt_cmd) else $error("odt not with cmd");
  property p_odt_len;
    $fell(on_die_termination) |-> odt_cnt_r == odt_exp;
  endproperty
  a_odt_len: assert property (p_odt_len) else $error("burst length");
  property p_idle;
    !on_die_termination |-> dq == '0 && lane_n;
  endproperty
  a_idle: assert property (p_idle) else $error("lanes not idle");
  property p_no_both;
    cmd == CMD_MRS |-> !(addr[MR_MASK_BIT] && addr[MR_INV_BIT]);
  endproperty
  a_no_both: assert property (p_no_both) else $error("mask and inv");
  property p_plain_lane;
    on_die_termination && !mode_r[MR_MASK_BIT] && !mode_r[MR_INV_BIT] |-> lane_n;
  endproperty
  a_plain_lane: assert property (p_plain_lane) else $error("lane used");
  property p_addr_idle;
    cmd == CMD_NOP |-> addr == '0;
  endproperty
  a_addr_idle: assert property (p_addr_idle) else $error("addr not 0");
  c_cal: cover property (cmd == CMD_WRITE && cs_n);
  c_chop: cover property ($fell(on_die_termination) && beats_r == BEATS_CHOP);
  c_mrs: cover property (cmd == CMD_MRS);
endmodule

// ### tb/dwb_write_burst_control_tb.sv
/*
  Bench for controller and device joined by the link interface.
  Assumes ref_clk at 50 MHz; stimulus goes through the register port except cfg_x4, dll_locked and rd_idx, driven straight to the device.
*/
`timescale 1ns/1ps
module dwb_write_burst_control_tb;
  import dwb_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [REG_AW-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [31:0] reg_rdata;
  logic cfg_x4 = 1'b0;
  logic dll_locked = 1'b1;
  logic [COL_W-1:0] rd_idx = '0;
  logic mem_re = 1'b0;
  logic pend_reg = 1'b0;
  logic pend_mem = 1'b0;
  logic [DQ_W-1:0] rd_data;
  logic bank_open, precharge_start, write_busy, cfg_fault, crc_p, crc_np;
  int n_fail = 0;
  int checks_done = 0;
  int n_pre = 0;
  int n_busy = 0;
  int pre_m = 0;
  logic bank_m = 1'b0;
  logic [31:0] rng = 32'h1E;
  logic [31:0] reg_q[$];
  logic [7:0] mem_q[$];
  logic [7:0] mem_m[64];
  // table entry: {dll, x4, ap, sel, mode}
  logic [21:0] tab[10] = '{{4'b1000, 18'h12000}, {4'b1010, 18'h12001},
    {4'b1001, 18'h12001}, {4'b1011, 18'h12002}, {4'b1000, 18'h12014},
    {4'b1001, 18'h12018}, {4'b1001, 18'h12A00}, {4'b1000, 18'h12060},
    {4'b1100, 18'h12064}, {4'b0010, 18'h12060}};
  dwb_link_if link ();
  dwb_ctrl i_dwb_ctrl (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .link(link));
  dwb_device i_dwb_device (.ref_clk(ref_clk), .rst_n(rst_n), .link(link),
    .cfg_x4(cfg_x4), .dll_locked(dll_locked), .rd_idx(rd_idx),
    .rd_data(rd_data), .bank_open(bank_open),
    .precharge_start(precharge_start), .write_busy(write_busy),
    .cfg_fault(cfg_fault), .crc_persistent(crc_p), .crc_nonpersistent(crc_np));
  dwb_link_sva i_dwb_link_sva (.ref_clk(ref_clk), .rst_n(rst_n), .ck(link.ck),
    .cs_n(link.cs_n), .cmd(link.cmd), .addr(link.addr), .on_die_termination(link.on_die_termination),
    .dq(link.dq), .lane_n(link.lane_n));
  always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
  // ==========================================================
  // helpers
  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // results land one cycle after the strobe; compare in arrival order
  always @(posedge ref_clk)
  begin
    if (pend_reg)
      chk("reg_rdata", reg_q.pop_front(), reg_rdata);
    if (pend_mem)
      chk("rd_data", 32'(mem_q.pop_front()), 32'(rd_data));
    if (precharge_start === 1'b1)
      n_pre++;
    if (write_busy === 1'b1)
      n_busy++;
    pend_reg <= reg_re;
    pend_mem <= mem_re;
  end
  // ==========================================================
  // bus tasks
  task automatic reg_wr(input logic [REG_AW-1:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge ref_clk);
    reg_we <= 1'b0;
  endtask
  task automatic reg_rd(input logic [REG_AW-1:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    reg_q.push_back(e);
    @(posedge ref_clk);
    reg_re <= 1'b0;
  endtask
  task automatic mem_rd(input logic [5:0] i);
    @(posedge ref_clk);
    rd_idx <= i;
    mem_re <= 1'b1;
    mem_q.push_back(mem_m[i]);
    @(posedge ref_clk);
    mem_re <= 1'b0;
  endtask
  task automatic wait_cmd(input logic [1:0] c);
    int n;
    n = 0;
    while (link.cmd !== c && n < 4000)
    begin
      @(posedge ref_clk);
      n++;
    end
    while ((link.cmd !== CMD_NOP || link.on_die_termination !== 1'b0) && n < 4000)
    begin
      @(posedge ref_clk);
      n++;
    end
    chk("link_wait", 32'h1, 32'(n < 4000));
    // controller stays busy one link period past the last beat
    repeat (2 * LINK_DIV) @(posedge ref_clk);
  endtask
  // ==========================================================
  // one mode set plus one write burst, then readback
  task automatic run_case(input logic [21:0] t, input logic [5:0] col);
    logic [63:0] d;
    logic [7:0] m;
    logic [3:0] n;
    int b0;
    int wb;
    d = {rnd(), rnd()};
    m = 8'(rnd());
    n = (t[1:0] == BL_CHOP || (t[1:0] == BL_OTF && !t[18])) ? 4'h4 : 4'h8;
    reg_wr(REG_MODE, 32'(t[17:0]));
    wait_cmd(CMD_MRS);
    reg_rd(REG_MODE, 32'(t[17:0]));
    cfg_x4 <= t[20];
    dll_locked <= t[21];
    reg_wr(REG_DLO, d[31:0]);
    reg_wr(REG_DHI, d[63:32]);
    reg_wr(REG_MASK, 32'(m));
    b0 = n_busy;
    reg_wr(REG_CMD, {1'b1, 18'h0, t[18], 1'b0, t[19], 4'h0, col});
    reg_rd(REG_STAT, 32'h1);
    wait_cmd(CMD_WRITE);
    dll_locked <= 1'b1;
    // device busy from capture to last beat, one link period per step
    wb = t[21] ? 8 * (int'(t[12:8]) + int'(t[17:13]) + int'(n) - 1) : 0;
    chk("write_busy", 32'(wb), 32'(n_busy - b0));
    if (t[21])
    begin
      for (int i = 0; i < n; i++)
        if (!(t[2] && !t[20] && m[i]))
          mem_m[col+6'(i)] = d[8*i+:8];
      bank_m = !t[19];
      pre_m += 32'(t[19]);
    end
    for (int i = 0; i < 8; i++)
      mem_rd(col + 6'(i));
    chk("bank_open", 32'(bank_m), 32'(bank_open));
    chk("precharge", 32'(pre_m), 32'(n_pre));
    chk("crc_p", 32'(t[4] & t[2]), 32'(crc_p));
    chk("crc_np", 32'(t[4] & !t[2]), 32'(crc_np));
    chk("cfg_fault", 32'h0, 32'(cfg_fault));
    $display("case %h done", t);
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    #(400000);
    chk("watchdog", 32'h0, 32'h1);
    test_done();
  end
  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    reg_rd(REG_MODE, 32'(MR_RESET));
    reg_rd(REG_STAT, 32'h0);
    chk("bank_open", 32'h0, 32'(bank_open));
    for (int k = 0; k < 8; k++)
      run_case(tab[0], 6'(8 * k));
    for (int k = 1; k < 10; k++)
      run_case(tab[k], 6'(rnd()));
    reg_wr(REG_MODE, 32'h1200C);
    reg_rd(REG_STAT, 32'h2);
    reg_rd(REG_MODE, 32'h12060);
    reg_wr(REG_STAT, 32'h2);
    reg_rd(REG_STAT, 32'h0);
    reg_rd(8'h20, 32'h0);
    repeat (2) @(posedge ref_clk);
    $display("refusal test done");
    test_done();
  end
endmodule

// ### verilog/dwb_ctrl.sv
/*
  Write controller end: register port for software, link clock divider,
  command sequencer with select latency, and beat driver.
  Assumes software waits for busy to clear before issuing new orders.
*/
`timescale 1ns/1ps
module dwb_ctrl
  import dwb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [REG_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  dwb_link_if.ctl link
);

  function automatic logic [DQ_W:0] drive_beat(
    input logic [63:0] data, input logic [7:0] mask,
    input logic [2:0] b, input logic [ADDR_W-1:0] mr);
    logic [DQ_W-1:0] d;
    logic [3:0] zeros;
    d = data[{b, 3'h0}+:8];
    zeros = 4'h0;
    for (int i = 0; i < DQ_W; i++)
    begin
      zeros = zeros + {3'h0, ~d[i]};
    end
    if (mr[MR_MASK_BIT])
    begin
      return {~mask[b], d};
    end
    // inversion keeps zeros on the lane to four or fewer
    if (mr[MR_INV_BIT] && zeros > 4'h4)
    begin
      return {1'b0, ~d};
    end
    return {1'b1, d};
  endfunction

  // ==========================================================
  // state
  dwb_cstate_e st_r, st_nxt;
  logic [2:0] div_r, div_nxt;
  logic [ADDR_W-1:0] mode_r, mode_nxt, shadow_r, shadow_nxt;
  logic [ADDR_W-1:0] op_addr_r, op_addr_nxt;
  logic [63:0] data_r, data_nxt;
  logic [7:0] mask_r, mask_nxt;
  logic mrs_pend_r, mrs_pend_nxt, go_pend_r, go_pend_nxt;
  logic op_mrs_r, op_mrs_nxt, rej_r, rej_nxt;
  logic [2:0] lead_r, lead_nxt;
  logic [5:0] wcnt_r, wcnt_nxt;
  logic [3:0] beat_r, beat_nxt, nbeats_r, nbeats_nxt;
  logic cs_n_r, cs_n_nxt, odt_r, odt_nxt, lane_r, lane_nxt;
  logic [1:0] cmd_r, cmd_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [DQ_W-1:0] dq_r, dq_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic tick, busy, send;
  logic [2:0] cal;

  assign tick = (div_r == DIV_LAST);
  assign busy = mrs_pend_r | go_pend_r | (st_r != C_IDLE);
  assign cal = mode_r[MR_CAL_LSB+:3];

  always_comb
  begin
    st_nxt = st_r;
    {mode_nxt, shadow_nxt, op_addr_nxt} = {mode_r, shadow_r, op_addr_r};
    {data_nxt, mask_nxt, mrs_pend_nxt, go_pend_nxt} =
      {data_r, mask_r, mrs_pend_r, go_pend_r};
    {op_mrs_nxt, rej_nxt, lead_nxt, wcnt_nxt} =
      {op_mrs_r, rej_r, lead_r, wcnt_r};
    {beat_nxt, nbeats_nxt, odt_nxt} = {beat_r, nbeats_r, odt_r};
    {dq_nxt, lane_nxt} = {dq_r, lane_r};
    div_nxt = div_r + 3'h1;
    rdata_nxt = 32'h0;
    send = 1'b0;
    if (reg_we && reg_addr == REG_STAT && reg_wdata[STAT_REJ_BIT])
    begin
      rej_nxt = 1'b0;
    end
    if (reg_we && !busy)
    begin
      case (reg_addr)
        REG_MODE:
        begin
          if (reg_wdata[MR_MASK_BIT] && reg_wdata[MR_INV_BIT])
          begin
            rej_nxt = 1'b1;
          end
          else
          begin
            shadow_nxt = reg_wdata[ADDR_W-1:0];
            mrs_pend_nxt = 1'b1;
          end
        end
        REG_CMD:
        begin
          op_addr_nxt = reg_wdata[ADDR_W-1:0];
          go_pend_nxt = reg_wdata[GO_BIT];
        end
        REG_DLO: data_nxt[31:0] = reg_wdata;
        REG_DHI: data_nxt[63:32] = reg_wdata;
        REG_MASK: mask_nxt = reg_wdata[7:0];
        default: ;
      endcase
    end
    if (reg_re)
    begin
      case (reg_addr)
        REG_MODE: rdata_nxt = 32'(mode_r);
        REG_CMD: rdata_nxt = 32'(op_addr_r);
        REG_DLO: rdata_nxt = data_r[31:0];
        REG_DHI: rdata_nxt = data_r[63:32];
        REG_MASK: rdata_nxt = {24'h0, mask_r};
        REG_STAT: rdata_nxt = {30'h0, rej_r, busy};
        default: rdata_nxt = 32'h0;
      endcase
    end
    // link pins change only half a link period before a rising edge
    cs_n_nxt = tick ? 1'b1 : cs_n_r;
    cmd_nxt = tick ? CMD_NOP : cmd_r;
    addr_nxt = tick ? '0 : addr_r;
    if (tick)
    begin
      case (st_r)
        C_IDLE:
        begin
          if (mrs_pend_r || go_pend_r)
          begin
            op_mrs_nxt = mrs_pend_r;
            mrs_pend_nxt = 1'b0;
            go_pend_nxt = mrs_pend_r & go_pend_r;
            cs_n_nxt = 1'b0;
            lead_nxt = cal - 3'h1;
            if (cal == 3'h0)
            begin
              send = 1'b1;
            end
            else
            begin
              st_nxt = C_LEAD;
            end
          end
        end
        C_LEAD:
        begin
          if (lead_r == 3'h0)
          begin
            send = 1'b1;
          end
          else
          begin
            lead_nxt = lead_r - 3'h1;
          end
        end
        C_WAIT:
        begin
          if (wcnt_r == 6'h0)
          begin
            {lane_nxt, dq_nxt} = drive_beat(data_r, mask_r, 3'h0, mode_r);
            beat_nxt = 4'h1;
            st_nxt = C_DATA;
          end
          else
          begin
            wcnt_nxt = wcnt_r - 6'h1;
          end
        end
        C_DATA:
        begin
          if (beat_r == nbeats_r)
          begin
            {lane_nxt, dq_nxt, odt_nxt} = {1'b1, 8'h00, 1'b0};
            st_nxt = C_IDLE;
          end
          else
          begin
            {lane_nxt, dq_nxt} =
              drive_beat(data_r, mask_r, beat_r[2:0], mode_r);
            beat_nxt = beat_r + 4'h1;
          end
        end
        default: st_nxt = C_IDLE;
      endcase
    end
    if (send)
    begin
      cmd_nxt = op_mrs_nxt ? CMD_MRS : CMD_WRITE;
      addr_nxt = op_mrs_nxt ? shadow_r : op_addr_r;
      st_nxt = op_mrs_nxt ? C_IDLE : C_WAIT;
      odt_nxt = ~op_mrs_nxt;
      wcnt_nxt = write_lat(mode_r) - 6'h1;
      nbeats_nxt = burst_beats(mode_r[MR_BL_LSB+:2],
                               op_addr_r[SEL_BIT]);
      if (op_mrs_nxt)
      begin
        mode_nxt = shadow_r;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      st_r <= C_IDLE;
      {div_r, mode_r, shadow_r, op_addr_r} <=
        {3'h0, MR_RESET, MR_RESET, 18'h00000};
      {data_r, mask_r, mrs_pend_r, go_pend_r} <= {64'h0, 8'h00, 2'h0};
      {op_mrs_r, rej_r, lead_r, wcnt_r} <= {2'h0, 3'h0, 6'h00};
      {beat_r, nbeats_r, odt_r, lane_r} <= {4'h0, BEATS_FULL, 2'h1};
      {cs_n_r, cmd_r, addr_r, dq_r} <= {1'b1, CMD_NOP, 18'h0, 8'h00};
      rdata_r <= 32'h0;
    end
    else
    begin
      st_r <= st_nxt;
      {div_r, mode_r, shadow_r, op_addr_r} <=
        {div_nxt, mode_nxt, shadow_nxt, op_addr_nxt};
      {data_r, mask_r, mrs_pend_r, go_pend_r} <=
        {data_nxt, mask_nxt, mrs_pend_nxt, go_pend_nxt};
      {op_mrs_r, rej_r, lead_r, wcnt_r} <=
        {op_mrs_nxt, rej_nxt, lead_nxt, wcnt_nxt};
      {beat_r, nbeats_r, odt_r, lane_r} <=
        {beat_nxt, nbeats_nxt, odt_nxt, lane_nxt};
      {cs_n_r, cmd_r, addr_r, dq_r} <= {cs_n_nxt, cmd_nxt, addr_nxt, dq_nxt};
      rdata_r <= rdata_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign link.ck = div_r[2];
  assign link.cs_n = cs_n_r;
  assign link.cmd = cmd_r;
  assign link.addr = addr_r;
  assign link.on_die_termination = odt_r;
  assign link.dq = dq_r;
  assign link.lane_n = lane_r;
  assign reg_rdata = rdata_r;

endmodule

// ### verilog/dwb_device.sv
/*
  Memory device end: samples the link on its own clock, decodes mode
  register and write commands, receives bursts into a byte array.
  Assumes the controller issues one write at a time and changes link
  pins half a link period before each rising link edge.
*/
`timescale 1ns/1ps
module dwb_device
  import dwb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  dwb_link_if.dev link,
  input wire logic cfg_x4,
  input wire logic dll_locked,
  input wire logic [COL_W-1:0] rd_idx,
  output logic [DQ_W-1:0] rd_data,
  output logic bank_open,
  output logic precharge_start,
  output logic write_busy,
  output logic cfg_fault,
  output logic crc_persistent,
  output logic crc_nonpersistent
);

  // ==========================================================
  // pin synchronisers
  localparam int SYNC_W = 4 + ADDR_W + DQ_W + 1;

  logic [SYNC_W-1:0] meta_r;
  logic [SYNC_W-1:0] pin_r;
  logic ck_last_r;
  logic s_ck;
  logic s_cs_n;
  logic [1:0] s_cmd;
  logic [ADDR_W-1:0] s_addr;
  logic [DQ_W-1:0] s_dq;
  logic s_lane_n;
  logic rise;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      meta_r <= '0;
      pin_r <= '0;
      ck_last_r <= 1'b0;
    end
    else
    begin
      meta_r <= {link.ck, link.cs_n, link.cmd, link.addr, link.dq,
                 link.lane_n};
      pin_r <= meta_r;
      ck_last_r <= s_ck;
    end
  end

  assign {s_ck, s_cs_n, s_cmd, s_addr, s_dq, s_lane_n} = pin_r;
  assign rise = s_ck & ~ck_last_r;

  // ==========================================================
  // command capture and burst sequencing
  dwb_dstate_e st_r, st_nxt;
  logic [ADDR_W-1:0] mr_r, mr_nxt;
  logic cal_arm_r, cal_arm_nxt;
  logic [2:0] cal_cnt_r, cal_cnt_nxt;
  logic [5:0] wcnt_r, wcnt_nxt;
  logic [3:0] beat_r, beat_nxt;
  logic [3:0] nbeats_r, nbeats_nxt;
  logic [COL_W-1:0] col_r, col_nxt;
  logic ap_r, ap_nxt;
  logic bank_open_r, bank_open_nxt;
  logic pre_r, pre_nxt;
  logic cap;
  logic take;
  logic masked;
  logic wr_en;
  logic [COL_W-1:0] wr_idx;
  logic [DQ_W-1:0] wr_byte;
  logic [2:0] cal;
  logic mask_on;
  logic inv_on;

  assign cal = mr_r[MR_CAL_LSB+:3];
  // mask needs the byte-wide configuration
  assign mask_on = mr_r[MR_MASK_BIT] & ~cfg_x4;
  assign inv_on = mr_r[MR_INV_BIT];

  always_comb
  begin
    st_nxt = st_r;
    mr_nxt = mr_r;
    cal_arm_nxt = cal_arm_r;
    cal_cnt_nxt = cal_cnt_r;
    wcnt_nxt = wcnt_r;
    beat_nxt = beat_r;
    nbeats_nxt = nbeats_r;
    col_nxt = col_r;
    ap_nxt = ap_r;
    bank_open_nxt = bank_open_r;
    pre_nxt = 1'b0;
    cap = 1'b0;
    take = 1'b0;
    // commands are ignored while the loop is unlocked
    if (rise && dll_locked)
    begin
      if (cal_arm_r)
      begin
        if (cal_cnt_r == 3'h1)
        begin
          cap = 1'b1;
          cal_arm_nxt = 1'b0;
        end
        else
        begin
          cal_cnt_nxt = cal_cnt_r - 3'h1;
        end
      end
      else if (!s_cs_n)
      begin
        if (cal == 3'h0)
        begin
          cap = 1'b1;
        end
        else
        begin
          cal_arm_nxt = 1'b1;
          cal_cnt_nxt = cal;
        end
      end
    end
    case (st_r)
      D_IDLE:
      begin
        if (cap && s_cmd == CMD_MRS)
        begin
          mr_nxt = s_addr;
        end
        else if (cap && s_cmd == CMD_WRITE)
        begin
          col_nxt = s_addr[COL_W-1:0];
          ap_nxt = s_addr[AP_BIT];
          nbeats_nxt = burst_beats(mr_r[MR_BL_LSB+:2], s_addr[SEL_BIT]);
          wcnt_nxt = write_lat(mr_r) - 6'h1;
          beat_nxt = 4'h0;
          st_nxt = D_WAIT;
        end
      end
      D_WAIT:
      begin
        if (rise)
        begin
          if (wcnt_r == 6'h0)
          begin
            take = 1'b1;
            beat_nxt = beat_r + 4'h1;
            st_nxt = D_DATA;
          end
          else
          begin
            wcnt_nxt = wcnt_r - 6'h1;
          end
        end
      end
      D_DATA:
      begin
        if (rise)
        begin
          take = 1'b1;
          beat_nxt = beat_r + 4'h1;
          if (beat_r == nbeats_r - 4'h1)
          begin
            st_nxt = D_IDLE;
            bank_open_nxt = ~ap_r;
            pre_nxt = ap_r;
          end
        end
      end
      default:
      begin
        st_nxt = D_IDLE;
      end
    endcase
  end

  // ==========================================================
  // lane decode: mask wins over inversion if both are set
  always_comb
  begin
    masked = mask_on & ~s_lane_n;
    wr_en = take & ~masked;
    wr_idx = col_r + COL_W'(beat_r);
    if (!mask_on && inv_on && !s_lane_n)
    begin
      wr_byte = ~s_dq;
    end
    else
    begin
      wr_byte = s_dq;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      st_r <= D_IDLE;
      mr_r <= MR_RESET;
      cal_arm_r <= 1'b0;
      cal_cnt_r <= 3'h0;
      wcnt_r <= 6'h0;
      beat_r <= 4'h0;
      nbeats_r <= BEATS_FULL;
      col_r <= '0;
      ap_r <= 1'b0;
      bank_open_r <= 1'b0;
      pre_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      mr_r <= mr_nxt;
      cal_arm_r <= cal_arm_nxt;
      cal_cnt_r <= cal_cnt_nxt;
      wcnt_r <= wcnt_nxt;
      beat_r <= beat_nxt;
      nbeats_r <= nbeats_nxt;
      col_r <= col_nxt;
      ap_r <= ap_nxt;
      bank_open_r <= bank_open_nxt;
      pre_r <= pre_nxt;
    end
  end

  // ==========================================================
  // byte array; contents are data, so no reset
  logic [DQ_W-1:0] mem_r [MEM_DEPTH];
  logic [DQ_W-1:0] rd_data_r;

  always_ff @(posedge ref_clk)
  begin
    if (wr_en)
    begin
      mem_r[wr_idx] <= wr_byte;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      rd_data_r <= '0;
    end
    else
    begin
      rd_data_r <= mem_r[rd_idx];
    end
  end

  // ==========================================================
  // status outputs
  assign rd_data = rd_data_r;
  assign bank_open = bank_open_r;
  assign precharge_start = pre_r;
  assign write_busy = (st_r != D_IDLE);
  assign cfg_fault = mr_r[MR_MASK_BIT] & mr_r[MR_INV_BIT];
  assign crc_persistent = mr_r[MR_CRC_BIT] & mr_r[MR_MASK_BIT];
  assign crc_nonpersistent = mr_r[MR_CRC_BIT] & ~mr_r[MR_MASK_BIT];

endmodule

// ### verilog/dwb_link_if.sv
/*
  Link between write controller and memory device: link clock, select,
  command, address, termination, data and shared mask/inversion lane.
  Assumes the controller drives every signal; the device only samples.
*/
`timescale 1ns/1ps
interface dwb_link_if;
  import dwb_pkg::*;
  logic ck;
  logic cs_n;
  logic [1:0] cmd;
  logic [ADDR_W-1:0] addr;
  logic on_die_termination;
  logic [DQ_W-1:0] dq;
  logic lane_n;
  modport ctl (output ck, cs_n, cmd, addr, on_die_termination, dq, lane_n);
  modport dev (input ck, cs_n, cmd, addr, on_die_termination, dq, lane_n);
endinterface

// ### verilog/dwb_pkg.sv
/*
  Shared constants for the write-burst link: command codes, mode register
  field layout, controller register map, timing counts and state types.
  Assumes both ends and the bench import it whole.
*/
// Operation
// - field 00 fixed eight; 01 select per command
// - field 10 forces four-beat chop always
// - per-command bit twelve: low chop, high eight
// - bit ten low: plain write, bank stays open
// - bit ten high: bank precharges after burst
// - masking only in byte-wide configurations
// - masking and inversion never enabled together
// - mask low: lane data dropped, byte kept
// - mask high: lane data stored to array
// - with crc, mask enable picks persistent mode
// - termination timing follows command, not select
// - writes honoured only with loop locked
package dwb_pkg;

  // ==========================================================
  // link geometry and timing
  localparam int ADDR_W = 18;
  localparam int DQ_W = 8;
  localparam int COL_W = 6;
  localparam int MEM_DEPTH = 64;
  localparam int CLK_PERIOD_NS = 20;
  localparam int LINK_PERIOD_NS = 160;
  localparam int LINK_DIV = LINK_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [2:0] DIV_LAST = 3'(LINK_DIV - 1);

  // ==========================================================
  // command codes and address bits
  localparam logic [1:0] CMD_NOP = 2'h0;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_MRS = 2'h2;
  localparam int AP_BIT = 10;
  localparam int SEL_BIT = 12;

  // ==========================================================
  // first mode register layout
  localparam int MR_BL_LSB = 0;
  localparam int MR_MASK_BIT = 2;
  localparam int MR_INV_BIT = 3;
  localparam int MR_CRC_BIT = 4;
  localparam int MR_CAL_LSB = 5;
  localparam int MR_AL_LSB = 8;
  localparam int MR_CWL_LSB = 13;
  localparam logic [ADDR_W-1:0] MR_RESET = 18'h12000;
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_CHOP = 2'h2;
  localparam logic [3:0] BEATS_FULL = 4'h8;
  localparam logic [3:0] BEATS_CHOP = 4'h4;

  // ==========================================================
  // controller register map
  localparam int REG_AW = 8;
  localparam logic [REG_AW-1:0] REG_MODE = 8'h00;
  localparam logic [REG_AW-1:0] REG_CMD = 8'h04;
  localparam logic [REG_AW-1:0] REG_DLO = 8'h08;
  localparam logic [REG_AW-1:0] REG_DHI = 8'h0C;
  localparam logic [REG_AW-1:0] REG_MASK = 8'h10;
  localparam logic [REG_AW-1:0] REG_STAT = 8'h14;
  localparam int GO_BIT = 31;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_REJ_BIT = 1;

  typedef enum logic [3:0] {
    C_IDLE = 4'b0001,
    C_LEAD = 4'b0010,
    C_WAIT = 4'b0100,
    C_DATA = 4'b1000
  } dwb_cstate_e;

  typedef enum logic [2:0] {
    D_IDLE = 3'b001,
    D_WAIT = 3'b010,
    D_DATA = 3'b100
  } dwb_dstate_e;

  // ==========================================================
  // shared decoders
  function automatic logic [3:0] burst_beats(input logic [1:0] bl,
                                             input logic sel);
    logic [3:0] n;
    n = BEATS_FULL;
    case (bl)
      BL_FIXED8: n = BEATS_FULL;
      BL_OTF: n = sel ? BEATS_FULL : BEATS_CHOP;
      BL_CHOP: n = BEATS_CHOP;
      default: n = BEATS_FULL;
    endcase
    return n;
  endfunction

  function automatic logic [5:0] write_lat(input logic [ADDR_W-1:0] mr);
    return {1'b0, mr[MR_AL_LSB+:5]} + {1'b0, mr[MR_CWL_LSB+:5]};
  endfunction

endpackage
